// ==== test_mode_calibration_loader.sv ====
/*
 Test mode calibration loader: mode stepping on the mode step pin,
 stepwise and serial calibration, feature word programming and the
 commit of both words to nonvolatile memory.
 Assumes pins are asynchronous to sys_clk, serial_clk is the fixture's
 serial clock and stands still between bits, and the memory takes a
 one cycle write request.
*/
// Overview of operation
// R1 - Mode pulses step hysteresis, quiet, chamber calibration
// R2 - Data low: comparator on, tap on, result out
// R3 - Serial clock steps the selected level
// R4 - Interconnect rise latches level for the mode
// R5 - Memory written only by final commit pulse
// R6 - Ten mode pulses select serial calibration mode
// R7 - Serial modes: data pin data, clock shifts
// R8 - Fixture sends fields lsb first, standby first
// R9 - Interconnect pulse after 17 bits stores word
// R10 - Calibration word field layout bits one-seventeen
// R11 - Two mode pulses select feature programming mode
// R12 - Fixture shifts complete 18-bit feature word
// R13 - Interconnect pulse of 10 ms stores features
// R14 - Feature change needs power cycle, full reentry
// R15 - Bits 17:16 battery trip, bit 18 unused
// R16 - Bits 15,14,12,11 enable their functions
// R17 - Bit 13 one disables alarm locating
// R18 - Bits 6,10,9 alarm memory and indications
// R19 - Bits 8:7 alarm memory timeout select
// R20 - Bit 5 selects quiet timer duration
// R21 - Bits 4,3 smart quiet, quiet in alarm
// R22 - Bit 2 quiet disable, bit 1 tone
// R23 - Power-up normal; mode pin high enters test
// R24 - Four pulses standby calibration, five hysteresis
// R25 - Comparator high when sense below level
// R26 - Sample data on serial clock rising edge
`timescale 1ns/1ns
`default_nettype none
`include "loader_map.svh"

module test_mode_calibration_loader #(
  parameter int unsigned STORE_MIN_CYCLES = `STORE_PULSE_MS * `SYS_CLK_KHZ
) (
  // Clocks and reset
  input  wire logic                     sys_clk,
  input  wire logic                     serial_clk,
  input  wire logic                     rstn,
  // Fixture pins
  input  wire logic                     mode_step_pin,
  input  wire logic                     prog_data_pin,
  input  wire logic                     interconnect_pin,
  // Analog side
  input  wire logic                     smoke_compare_result,
  input  wire logic                     io_dump,
  output var  logic                     comparator_enable,
  output var  logic                     analog_tap_enable,
  output var  logic [4:0]               sense_level,
  output var  logic                     diag_output_pin,
  // Mode, memory and configuration
  output var  loader_pkg::mode_t         mode,
  output var  loader_pkg::nvm_req_t      nvm_req,
  output var  loader_pkg::cal_word_t     cal_cfg,
  output var  loader_pkg::feature_word_t feature_cfg
);

  localparam logic [16:0] STORE_MIN = 17'(STORE_MIN_CYCLES);

  // Serial clock domain state
  typedef struct packed {
    logic bit_cap;
    logic toggle;
  } link_t;

  // System clock domain state
  typedef struct packed {
    logic                      step_s1;
    logic                      step_s2;
    logic                      step_prev;
    logic                      data_s1;
    logic                      data_s2;
    logic                      io_s1;
    logic                      io_s2;
    logic                      io_prev;
    logic                      cmp_s1;
    logic                      cmp_s2;
    logic                      tog_s1;
    logic                      tog_s2;
    logic                      tog_prev;
    loader_pkg::mode_t         mode;
    logic [4:0]                pulse_cnt;
    loader_pkg::cal_word_t     work;
    loader_pkg::cal_word_t     saved;
    logic [3:0]                saved_flags;
    logic [17:0]               shift;
    logic [4:0]                bit_cnt;
    logic [16:0]               hi_cnt;
    logic                      feat_locked;
    logic                      comp_en;
    logic                      tap_en;
    logic [4:0]                level;
    logic                      diag;
    loader_pkg::nvm_req_t      nvm;
    loader_pkg::cal_word_t     cal_q;
    loader_pkg::feature_word_t feat_q;
  } state_t;

  link_t  link_q;
  link_t  link_d;
  state_t st_q;
  state_t st_d;
  logic   step_rise;
  logic   io_rise;
  logic   io_fall;
  logic   feed_ev;
  logic   cal_active;

  // Pulse count to mode
  function automatic loader_pkg::mode_t mode_of(input logic [4:0] cnt);
    case (cnt)
      `PULSES_FEATURE: mode_of = loader_pkg::feature_program_mode; // R11
      `PULSES_STANDBY: mode_of = loader_pkg::standby_cal_mode;     // R24
      `PULSES_HYST:    mode_of = loader_pkg::hysteresis_cal_mode;  // R24
      `PULSES_QUIET:   mode_of = loader_pkg::quiet_cal_mode;       // R1
      `PULSES_CHAMBER: mode_of = loader_pkg::chamber_cal_mode;     // R1
      `PULSES_COMMIT:  mode_of = loader_pkg::commit_cal_mode;
      `PULSES_SERIAL:  mode_of = loader_pkg::serial_cal_mode;      // R6
      default:         mode_of = loader_pkg::other_test_mode;
    endcase
  endfunction : mode_of

  // Serial clock side: capture data and flag the edge by a toggle
  always_comb begin
    link_d         = link_q;
    link_d.bit_cap = prog_data_pin;  // R26 R7
    link_d.toggle  = ~link_q.toggle;
  end

  always_ff @(posedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  // Edge events from synchronised pins
  assign step_rise  = st_q.step_s2 & ~st_q.step_prev;
  assign io_rise    = st_q.io_s2 & ~st_q.io_prev;
  assign io_fall    = ~st_q.io_s2 & st_q.io_prev;
  assign feed_ev    = st_q.tog_s2 ^ st_q.tog_prev;
  assign cal_active = (st_q.mode == loader_pkg::standby_cal_mode) ||
                      (st_q.mode == loader_pkg::hysteresis_cal_mode) ||
                      (st_q.mode == loader_pkg::quiet_cal_mode) ||
                      (st_q.mode == loader_pkg::chamber_cal_mode);

  // Next state of the system side
  always_comb begin
    st_d                   = st_q;
    st_d.step_s1           = mode_step_pin;
    st_d.step_s2           = st_q.step_s1;
    st_d.step_prev         = st_q.step_s2;
    st_d.data_s1           = prog_data_pin;
    st_d.data_s2           = st_q.data_s1;
    st_d.io_s1             = interconnect_pin;
    st_d.io_s2             = st_q.io_s1;
    st_d.io_prev           = st_q.io_s2;
    st_d.cmp_s1            = smoke_compare_result;
    st_d.cmp_s2            = st_q.cmp_s1;
    st_d.tog_s1            = link_q.toggle;
    st_d.tog_s2            = st_q.tog_s1;
    st_d.tog_prev          = st_q.tog_s2;
    st_d.nvm.write_cal     = 1'b0;
    st_d.nvm.write_feature = 1'b0;

    // High time of the interconnect pin
    if (!st_q.io_s2) begin
      st_d.hi_cnt = 17'h0_0000;
    end else if (st_q.hi_cnt != `STORE_CNT_MAX) begin
      st_d.hi_cnt = 17'(st_q.hi_cnt + 17'h0_0001);
    end

    // Mode stepping
    case (st_q.mode)
      loader_pkg::normal_operation: begin
        if (st_q.step_s2) begin
          st_d.mode      = loader_pkg::first_test_mode; // R23
          st_d.pulse_cnt = 5'h00;
        end
      end
      default: begin
        if (step_rise && st_q.data_s2 && st_q.pulse_cnt != `PULSE_COUNT_MAX) begin
          st_d.pulse_cnt = 5'(st_q.pulse_cnt + 5'h01);
          st_d.mode      = mode_of(5'(st_q.pulse_cnt + 5'h01)); // R1
          st_d.bit_cnt   = 5'h00;
        end
      end
    endcase

    // Mode actions
    case (st_q.mode)
      loader_pkg::standby_cal_mode: begin
        if (feed_ev) begin
          st_d.work.standby_level_field = 5'(st_q.work.standby_level_field + 5'h01); // R3
        end
        if (io_rise) begin
          st_d.saved.standby_level_field = st_q.work.standby_level_field; // R4
          st_d.saved_flags[0]            = 1'b1;
        end
      end
      loader_pkg::hysteresis_cal_mode: begin
        if (feed_ev) begin
          st_d.work.hysteresis_level_field = 3'(st_q.work.hysteresis_level_field + 3'h1); // R3
        end
        if (io_rise) begin
          st_d.saved.hysteresis_level_field = st_q.work.hysteresis_level_field; // R4
          st_d.saved_flags[1]               = 1'b1;
        end
      end
      loader_pkg::quiet_cal_mode: begin
        if (feed_ev) begin
          st_d.work.quiet_level_field = 4'(st_q.work.quiet_level_field + 4'h1); // R3
        end
        if (io_rise) begin
          st_d.saved.quiet_level_field = st_q.work.quiet_level_field; // R4
          st_d.saved_flags[2]          = 1'b1;
        end
      end
      loader_pkg::chamber_cal_mode: begin
        if (feed_ev) begin
          st_d.work.chamber_level_field = 5'(st_q.work.chamber_level_field + 5'h01); // R3
        end
        if (io_rise) begin
          st_d.saved.chamber_level_field = st_q.work.chamber_level_field; // R4
          st_d.saved_flags[3]            = 1'b1;
        end
      end
      loader_pkg::commit_cal_mode: begin
        // Only a full set of saved levels goes to memory
        if (io_rise && st_q.saved_flags == `ALL_SAVED) begin
          st_d.cal_q         = st_q.saved; // R5
          st_d.nvm.cal_word  = st_q.saved;
          st_d.nvm.write_cal = 1'b1;
        end
      end
      loader_pkg::serial_cal_mode: begin
        if (feed_ev) begin
          st_d.shift = {1'b0, link_q.bit_cap, st_q.shift[16:1]}; // R7 R10
          if (st_q.bit_cnt != `BIT_COUNT_MAX) begin
            st_d.bit_cnt = 5'(st_q.bit_cnt + 5'h01);
          end
        end
        if (io_rise && st_q.bit_cnt >= 5'(`CAL_WORD_BITS)) begin
          st_d.cal_q         = loader_pkg::cal_word_t'(st_q.shift[16:0]); // R9 R10
          st_d.nvm.cal_word  = loader_pkg::cal_word_t'(st_q.shift[16:0]);
          st_d.nvm.write_cal = 1'b1;
        end
      end
      loader_pkg::feature_program_mode: begin
        if (feed_ev) begin
          st_d.shift = {link_q.bit_cap, st_q.shift[17:1]}; // R7
          if (st_q.bit_cnt != `BIT_COUNT_MAX) begin
            st_d.bit_cnt = 5'(st_q.bit_cnt + 5'h01);
          end
        end
        // Long enough pulse on a full word; one store per power-up
        if (io_fall && st_q.hi_cnt >= STORE_MIN && !st_q.feat_locked &&
            st_q.bit_cnt >= 5'(`FEATURE_WORD_BITS)) begin
          st_d.feat_q            = loader_pkg::feature_word_t'(st_q.shift); // R13 R15 R16
          st_d.nvm.feature_word  = loader_pkg::feature_word_t'(st_q.shift);
          st_d.nvm.write_feature = 1'b1;
          st_d.feat_locked       = 1'b1; // R14
        end
      end
      default: begin
      end
    endcase

    // Analog controls and diagnostic output
    st_d.comp_en = cal_active & ~st_q.data_s2; // R2
    st_d.tap_en  = cal_active & ~st_q.data_s2; // R2
    if (cal_active) begin
      st_d.diag = ~st_q.data_s2 & st_q.cmp_s2; // R2 R25
    end else if (st_q.mode == loader_pkg::normal_operation || st_q.mode == loader_pkg::first_test_mode) begin
      st_d.diag = io_dump;
    end else begin
      st_d.diag = 1'b0;
    end

    // Level shown at the tap for the active calibration
    case (st_q.mode)
      loader_pkg::standby_cal_mode:    st_d.level = st_q.work.standby_level_field;
      loader_pkg::hysteresis_cal_mode: st_d.level = {2'b00, st_q.work.hysteresis_level_field};
      loader_pkg::quiet_cal_mode:      st_d.level = {1'b0, st_q.work.quiet_level_field};
      loader_pkg::chamber_cal_mode:    st_d.level = st_q.work.chamber_level_field;
      default:                         st_d.level = `RESET_LEVEL;
    endcase
  end

  // System side registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from registers
  assign comparator_enable = st_q.comp_en;
  assign analog_tap_enable = st_q.tap_en;
  assign sense_level       = st_q.level;
  assign diag_output_pin   = st_q.diag;
  assign mode              = st_q.mode;
  assign nvm_req           = st_q.nvm;
  assign cal_cfg           = st_q.cal_q;
  assign feature_cfg       = st_q.feat_q; // R17 R18 R19 R20 R21 R22

  // Mode step pulse with data pin high
  sequence step_pulse_s;
    st_q.step_s2 && !st_q.step_prev && st_q.data_s2;
  endsequence

  // Long interconnect pulse ending on a full feature word
  sequence long_store_s;
    (st_q.mode == loader_pkg::feature_program_mode) && io_fall && (st_q.hi_cnt >= STORE_MIN) &&
    !st_q.feat_locked && (st_q.bit_cnt >= 5'd18);
  endsequence

  chk_test_entry: assert property (@(posedge sys_clk) disable iff (!rstn) // R23
    (st_q.mode == loader_pkg::normal_operation) && st_q.step_s2 |=> (st_q.mode == loader_pkg::first_test_mode))
    else $error("mode pin high did not enter first test mode");

  chk_quiet_step: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    (st_q.mode == loader_pkg::hysteresis_cal_mode) ##0 step_pulse_s |=> (st_q.mode == loader_pkg::quiet_cal_mode))
    else $error("pulse did not step to quiet calibration");

  chk_serial_entry: assert property (@(posedge sys_clk) disable iff (!rstn) // R6
    (st_q.pulse_cnt == 5'h09) ##0 step_pulse_s |=> (st_q.mode == loader_pkg::serial_cal_mode))
    else $error("tenth pulse did not select serial calibration");

  chk_feature_entry: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    (st_q.pulse_cnt == 5'h01) && (st_q.mode != loader_pkg::normal_operation) ##0 step_pulse_s
    |=> (st_q.mode == loader_pkg::feature_program_mode))
    else $error("second pulse did not select feature mode");

  chk_standby_entry: assert property (@(posedge sys_clk) disable iff (!rstn) // R24
    (st_q.pulse_cnt == 5'h03) && (st_q.mode != loader_pkg::normal_operation) ##0 step_pulse_s
    |=> (st_q.mode == loader_pkg::standby_cal_mode))
    else $error("fourth pulse did not select standby calibration");

  chk_comp_route: assert property (@(posedge sys_clk) disable iff (!rstn) // R2
    cal_active && !st_q.data_s2 |=> comparator_enable && analog_tap_enable && (diag_output_pin == $past(st_q.cmp_s2)))
    else $error("comparator not routed in calibration");

  chk_level_step: assert property (@(posedge sys_clk) disable iff (!rstn) // R3
    (st_q.mode == loader_pkg::standby_cal_mode) && feed_ev
    |=> (st_q.work.standby_level_field == 5'($past(st_q.work.standby_level_field) + 5'h01)))
    else $error("serial clock did not step the level");

  chk_level_save: assert property (@(posedge sys_clk) disable iff (!rstn) // R4
    (st_q.mode == loader_pkg::quiet_cal_mode) && io_rise
    |=> (st_q.saved.quiet_level_field == $past(st_q.work.quiet_level_field)) && st_q.saved_flags[2])
    else $error("interconnect rise did not save the level");

  chk_no_early_write: assert property (@(posedge sys_clk) disable iff (!rstn) // R5
    nvm_req.write_cal |-> ($past(st_q.mode) == loader_pkg::serial_cal_mode) ||
                          (($past(st_q.mode) == loader_pkg::commit_cal_mode) && ($past(st_q.saved_flags) == 4'hf)))
    else $error("calibration written before commit");

  chk_serial_store: assert property (@(posedge sys_clk) disable iff (!rstn) // R9
    (st_q.mode == loader_pkg::serial_cal_mode) && io_rise && (st_q.bit_cnt >= 5'd17)
    |=> nvm_req.write_cal && (nvm_req.cal_word == $past(st_q.shift[16:0])) ##1 !nvm_req.write_cal)
    else $error("serial calibration word not stored");

  chk_feature_store: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
    long_store_s |=> nvm_req.write_feature && (feature_cfg == $past(st_q.shift)) ##1 !nvm_req.write_feature)
    else $error("long interconnect pulse did not store features");

  chk_short_pulse: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
    io_fall && (st_q.hi_cnt < STORE_MIN) |=> !nvm_req.write_feature)
    else $error("short interconnect pulse stored features");

  chk_shift_order: assert property (@(posedge sys_clk) disable iff (!rstn) // R8
    (st_q.mode == loader_pkg::serial_cal_mode) && feed_ev |=> (st_q.shift[15:0] == $past(st_q.shift[16:1])))
    else $error("calibration bits shifted in wrong order");

endmodule : test_mode_calibration_loader
`default_nettype wire

// ==== loader_map.svh ====
/*
 Constants of the test mode calibration loader: word widths, mode pulse
 counts, reset values and the store pulse timing.
 Assumes inclusion by bare name from the package and the loader module.
*/
`ifndef LOADER_MAP_SVH
`define LOADER_MAP_SVH

// Word widths
`define CAL_WORD_BITS     17
`define FEATURE_WORD_BITS 18

// Mode step pulse counts seen from the first test mode, and count limits
`define PULSES_FEATURE    5'h02
`define PULSES_STANDBY    5'h04
`define PULSES_HYST       5'h05
`define PULSES_QUIET      5'h06
`define PULSES_CHAMBER    5'h07
`define PULSES_COMMIT     5'h08
`define PULSES_SERIAL     5'h0a
`define PULSE_COUNT_MAX   5'h1f
`define BIT_COUNT_MAX     5'h1f

// Reset values and the full set of saved flags
`define RESET_LEVEL       5'h00
`define RESET_FLAGS       4'h0
`define ALL_SAVED         4'hf

// Store pulse timing
`define STORE_PULSE_MS    10
`define SYS_CLK_KHZ       10000
`define STORE_CNT_MAX     17'h1_ffff

`endif

// ==== loader_pkg.sv ====
/*
 Types of the test mode calibration loader: modes, calibration and
 feature word layouts, the memory write request.
 Assumes loader_map.svh is on the include path.
*/
`include "loader_map.svh"

package loader_pkg;

  // Operating and test modes
  typedef enum logic [3:0] {
    normal_operation, first_test_mode, feature_program_mode, standby_cal_mode,
    hysteresis_cal_mode, quiet_cal_mode, chamber_cal_mode, commit_cal_mode,
    serial_cal_mode, other_test_mode
  } mode_t;

  // Calibration word, bit 17 down to bit 1
  typedef struct packed {
    logic [4:0] chamber_level_field;
    logic [3:0] quiet_level_field;
    logic [2:0] hysteresis_level_field;
    logic [4:0] standby_level_field;
  } cal_word_t;

  // Feature word, bit 18 down to bit 1
  typedef struct packed {
    logic       unimplemented;
    logic [1:0] battery_trip_field;    // 00 7.5V, 01 7.8V, 10 6.9V, 11 7.2V
    logic       end_of_life_enable;
    logic       co_interconnect_enable;
    logic       alarm_locate_disable;  // 1 turns locating off
    logic       horn_sync_enable;
    logic       battery_quiet_enable;
    logic       memory_chirp_enable;
    logic       memory_led_enable;
    logic [1:0] memory_timeout_select; // 00 24h, 01 48h, 10 0h, 11 never
    logic       alarm_memory_enable;
    logic       quiet_duration_select; // 1 80 s, 0 9 min
    logic       smart_quiet_enable;
    logic       quiet_only_in_alarm;
    logic       quiet_disable_n;       // 1 disables quiet
    logic       tone_select;           // 1 continuous, 0 temporal
  } feature_word_t;

  // Request to the nonvolatile memory
  typedef struct packed {
    logic          write_cal;
    logic          write_feature;
    cal_word_t     cal_word;
    feature_word_t feature_word;
  } nvm_req_t;

endpackage : loader_pkg

// ==== loader_fixture.sv ====
/*
 Programming fixture model: drives the mode step, data, interconnect
 and serial clock pins of the loader.
 Assumes the bench calls its tasks; pins move on sys_clk falling edges except the serial clock fall,
 and the serial clock pulses once per bit, standing still in between.
*/
`timescale 1ns/1ns
`default_nettype none

module loader_fixture (
  // Reference clock
  input  wire logic sys_clk,
  // Fixture pins
  output var  logic mode_step_pin,
  output var  logic prog_data_pin,
  output var  logic interconnect_pin,
  output var  logic serial_clk
);
  // All pins low, as at power-up
  task automatic power_down;
    mode_step_pin    = 1'b0;
    prog_data_pin    = 1'b0;
    interconnect_pin = 1'b0;
    serial_clk       = 1'b0;
  endtask : power_down

  initial power_down();

  // Wait a number of falling edges
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle

  // Data pin level, held long enough to be synced
  task automatic set_data(input logic b);
    prog_data_pin = b;
    idle(5);
  endtask : set_data

  // Mode pin held high, then data high before any step pulse
  task automatic enter_test;
    mode_step_pin = 1'b1;
    idle(6);
    set_data(1'b1);
  endtask : enter_test

  // High-low-high pulses on the mode step pin
  task automatic step(input int n);
    repeat (n) begin
      mode_step_pin = 1'b0;
      idle(5);
      mode_step_pin = 1'b1;
      idle(5);
    end
  endtask : step

  // Data set up, one 62 ns high clock pulse, data held well past the rise
  task automatic send_bit(input logic b);
    prog_data_pin = b;
    idle(2);
    serial_clk = 1'b1;
    #62;
    serial_clk = 1'b0;
    #63;
    idle(5);
  endtask : send_bit

  // Word sent from bit 1 upward, so each field goes lsb first
  task automatic send_word(input logic [17:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      send_bit(w[i]);
    end
  endtask : send_word

  // Interconnect high for hi cycles, then low
  task automatic io_pulse(input int hi);
    interconnect_pin = 1'b1;
    idle(hi);
    interconnect_pin = 1'b0;
    idle(6);
  endtask : io_pulse
endmodule : loader_fixture

`default_nettype wire

// ==== test_mode_calibration_loader_tb.sv ====
/*
 Self-checking bench of the loader: stepwise calibration and commit,
 serial calibration, feature programming with a refused short pulse.
 Assumes loader_fixture drives the pins; store pulse shortened to 20.
*/
`timescale 1ns/1ns
`default_nettype none

module test_mode_calibration_loader_tb;
  localparam int unsigned STORE = 20;
  logic                      sys_clk;
  logic                      rstn;
  logic                      smoke_compare_result;
  logic                      io_dump;
  logic                      serial_clk;
  logic                      mode_step_pin;
  logic                      prog_data_pin;
  logic                      interconnect_pin;
  logic                      comparator_enable;
  logic                      analog_tap_enable;
  logic                      diag_output_pin;
  logic [4:0]                sense_level;
  loader_pkg::mode_t         mode;
  loader_pkg::nvm_req_t      nvm_req;
  loader_pkg::cal_word_t     cal_cfg;
  loader_pkg::feature_word_t feature_cfg;
  logic [18:0]               exp_q[$];
  logic [18:0]               got_w, exp_w;
  logic [31:0]               seed = 32'h0000_5a81;
  int                        err_count = 0;
  int                        check_count = 0;

  always #50 sys_clk = ~sys_clk;

  test_mode_calibration_loader #(.STORE_MIN_CYCLES(STORE)) i_dut (
    .sys_clk(sys_clk), .serial_clk(serial_clk), .rstn(rstn),
    .mode_step_pin(mode_step_pin), .prog_data_pin(prog_data_pin),
    .interconnect_pin(interconnect_pin), .smoke_compare_result(smoke_compare_result),
    .io_dump(io_dump), .comparator_enable(comparator_enable),
    .analog_tap_enable(analog_tap_enable), .sense_level(sense_level),
    .diag_output_pin(diag_output_pin), .mode(mode), .nvm_req(nvm_req),
    .cal_cfg(cal_cfg), .feature_cfg(feature_cfg));

  loader_fixture i_fix (
    .sys_clk(sys_clk), .mode_step_pin(mode_step_pin), .prog_data_pin(prog_data_pin),
    .interconnect_pin(interconnect_pin), .serial_clk(serial_clk));

  // Xorshift source of stimulus
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Level and mode comparison
  task automatic cmp_val(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t level got %h exp %h", $time, got, exp);
    end
  endtask : cmp_val

  // Memory write comparison, kind bit on top
  task automatic cmp_word(input logic [18:0] got, input logic [18:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t write got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // Any write takes the oldest note; an unexpected one meets an unknown
  always @(negedge sys_clk) begin
    if (nvm_req.write_cal === 1'b1 || nvm_req.write_feature === 1'b1) begin
      exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 19'bx;
      got_w = nvm_req.write_cal ? {2'b10, nvm_req.cal_word} : {1'b0, nvm_req.feature_word};
      cmp_word(got_w, exp_w);
      got_w = nvm_req.write_cal ? {2'b10, cal_cfg} : {1'b0, feature_cfg};
      cmp_word(got_w, exp_w);
    end
  end

  // Bounded wait for every noted write
  task automatic drain;
    int n = 0;
    while (exp_q.size() != 0 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    if (exp_q.size() != 0) begin
      err_count++;
      $display("CHECK FAILED t=%0t write missing", $time);
      end_of_test();
    end
  endtask : drain

  // Power cycle: pins low, reset five cycles
  task automatic do_reset;
    i_fix.power_down();
    rstn = 1'b0;
    io_dump = ^rnd();
    i_fix.idle(5);
    rstn = 1'b1;
    i_fix.idle(2);
    cmp_val(18'(mode), 18'(loader_pkg::normal_operation));
    cmp_val(18'(diag_output_pin), 18'(io_dump));
    io_dump = ~io_dump;
    i_fix.enter_test();
    cmp_val(18'(mode), 18'(loader_pkg::first_test_mode));
    cmp_val(18'(diag_output_pin), 18'(io_dump));
  endtask : do_reset

  initial begin
    logic [17:0] w;
    int          k;
    int          lvl;
    int          pos;
    int          widths [4] = '{5, 3, 4, 5};
    // Quiet levels before the first edge
    sys_clk = 1'b0;
    rstn = 1'b0;
    smoke_compare_result = 1'b0;
    io_dump = 1'b0;
    // Stepwise calibration of all four fields, counts crossing the wrap
    do_reset();
    i_fix.step(4);
    w = '0;
    pos = 0;
    for (int m = 0; m < 4; m++) begin
      cmp_val(18'(mode), 18'(loader_pkg::standby_cal_mode) + 18'(m));
      i_fix.set_data(1'b0);
      cmp_val({16'h0000, comparator_enable, analog_tap_enable}, 18'h0_0003);
      k = int'(rnd() % ((32'h1 << widths[m]) + 2));
      repeat (k) i_fix.send_bit(1'b0);
      lvl = k % (1 << widths[m]);
      cmp_val(18'(sense_level), 18'(lvl));
      smoke_compare_result = 1'b1;
      i_fix.idle(6);
      cmp_val(18'(diag_output_pin), 18'h0_0001);
      smoke_compare_result = 1'b0;
      i_fix.idle(6);
      cmp_val(18'(diag_output_pin), 18'h0_0000);
      i_fix.io_pulse(5);
      w = w | (18'(lvl) << pos);
      pos += widths[m];
      i_fix.set_data(1'b1);
      i_fix.step(1);
    end
    cmp_val(18'(mode), 18'(loader_pkg::commit_cal_mode));
    exp_q.push_back({1'b1, w});
    i_fix.io_pulse(5);
    drain();
    // Serial calibration word
    do_reset();
    i_fix.step(10);
    cmp_val(18'(mode), 18'(loader_pkg::serial_cal_mode));
    w = 18'(rnd());
    w[17] = 1'b0;
    i_fix.send_word(w, 17);
    exp_q.push_back({1'b1, w});
    i_fix.io_pulse(5);
    drain();
    // Feature word: short store pulse refused, long one stores
    do_reset();
    i_fix.step(2);
    cmp_val(18'(mode), 18'(loader_pkg::feature_program_mode));
    w = 18'(rnd());
    w[17] = 1'b0;
    i_fix.send_word(w, 18);
    i_fix.io_pulse(STORE - 10);
    exp_q.push_back({1'b0, w});
    i_fix.io_pulse(STORE + 5);
    drain();
    end_of_test();
  end
endmodule : test_mode_calibration_loader_tb

`default_nettype wire
